// *** logic/mtcm_top.sv ***
// multifunction timer: dual capture, dual timer, capture plus timer
//
// Contract
// - Mode select field in mode control register picks modes 2, 3, 4.
// - Mode 2: valid A edge copies counter one into capture A.
// - Mode 2: valid B edge copies counter one into capture B.
// - Mode 2: each input edge polarity set by its own select bit.
// - Mode 2: with pin enable, capture then preset counter one to FFFF.
// - Mode 2: separate A, B, underflow pending flags, each gated.
// - Mode 2: counter two is a system timer setting pending D.
// - Mode 2: counter one stops on event or accumulate clock.
// - Mode 2: counter two accepts every clock source.
// - Mode 3: counter one reloads from A, toggles A output.
// - Mode 3: counter one underflow sets pending A.
// - Mode 3: counter two reloads from B, sets pending D.
// - Mode 3: B pin may clock either counter; else prescaled clock.
// - Software sets the A output starting level.
// - Mode 4: counter one reloads from A, toggles, sets pending A.
// - Mode 4: valid B edge copies counter two into B, pending B.
// - Mode 4: with B pin enable, capture then preset counter two.
// - Mode 4: counter two underflow sets pending D.
// - Mode 4: B edge polarity from B edge select bit.
// - Mode 4: counter two stops on event clock; counter one any.
// - Pending A, B, C drive irq line A; D drives irq line B.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
module mtcm_top #(
	parameter int PRSC_W = mtcm_pkg::PRSC_W_DEF
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic timer_pin_a_in,
	input wire logic timer_pin_b_in,
	output logic timer_pin_a_out,
	output logic timer_pin_a_oe_out,
	output logic irq_a_out,
	output logic irq_b_out
);

	// refuse prescaler widths the register cannot hold
	if (PRSC_W < 1 || PRSC_W > 16) begin : g_bad_prsc
		$error("PRSC_W must be 1 to 16");
	end

	// edge select: 1 picks rising, 0 picks falling
	function automatic logic mtcm_edge(input logic prev, input logic cur,
		input logic rise);
		mtcm_edge = rise ? (cur & ~prev) : (~cur & prev);
	endfunction

	// clock source decode for one counter
	function automatic logic mtcm_src_tick(input logic [2:0] sel,
		input logic ptick, input logic bevt, input logic blvl);
		case (sel)
			mtcm_pkg::CK_PRESC: mtcm_src_tick = ptick;
			mtcm_pkg::CK_EVENT: mtcm_src_tick = bevt;
			mtcm_pkg::CK_PACC: mtcm_src_tick = ptick & blvl;
			default: mtcm_src_tick = 1'b0;
		endcase
	endfunction

	logic a_s1_reg, a_s2_reg, a_s3_reg;
	logic b_s1_reg, b_s2_reg, b_s3_reg;
	logic [15:0] cnt1_reg, cra_reg, crb_reg, cnt2_reg;
	logic [PRSC_W-1:0] prsc_reg, pcnt_reg;
	logic [5:0] ckc_reg;
	logic [7:0] mctrl_reg;
	logic [3:0] ien_reg, pend_reg;
	logic pready_reg, pslverr_reg, pin_a_reg, oe_reg;
	logic irq_a_reg, irq_b_reg;
	logic [31:0] prdata_reg;

	// pin synchronisers; the second and third stages feed logic
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			{a_s1_reg, a_s2_reg, a_s3_reg} <= 3'h0;
			{b_s1_reg, b_s2_reg, b_s3_reg} <= 3'h0;
		end else if (ce_in) begin
			{a_s3_reg, a_s2_reg, a_s1_reg} <= {a_s2_reg, a_s1_reg,
				timer_pin_a_in};
			{b_s3_reg, b_s2_reg, b_s1_reg} <= {b_s2_reg, b_s1_reg,
				timer_pin_b_in};
		end
	end

	// mode control decode
	wire [2:0] mode = mctrl_reg[mtcm_pkg::MC_MODE_LSB +: 3];
	wire m2 = (mode == mtcm_pkg::MODE_CAP2);
	wire m3 = (mode == mtcm_pkg::MODE_DUAL3);
	wire m4 = (mode == mtcm_pkg::MODE_CAPT4);
	wire m34 = m3 | m4;
	wire pen_a = mctrl_reg[mtcm_pkg::MC_PEN_A];
	wire pen_b = mctrl_reg[mtcm_pkg::MC_PEN_B];
	wire [2:0] ck1 = ckc_reg[mtcm_pkg::CK1_LSB +: 3];
	wire [2:0] ck2 = ckc_reg[mtcm_pkg::CK2_LSB +: 3];

	// pin events on synchronised levels; pulses must last a clock
	wire a_edge = mtcm_edge(a_s3_reg, a_s2_reg,
		mctrl_reg[mtcm_pkg::MC_EDGE_A]);
	wire b_edge = mtcm_edge(b_s3_reg, b_s2_reg,
		mctrl_reg[mtcm_pkg::MC_EDGE_B]);
	wire cap_a1 = m2 & a_edge;
	wire cap_b1 = m2 & b_edge;
	wire cap_b2 = m4 & b_edge;
	wire pre1 = (cap_a1 & pen_a) | (cap_b1 & pen_b);
	wire pre2 = cap_b2 & pen_b;

	// prescaled system clock tick
	wire ptick = (pcnt_reg == '0);

	// counter clocks; capture blocks the event sources of counter one in mode 2 and of counter two in mode 4
	wire raw1 = mtcm_src_tick(ck1, ptick, b_edge, b_s2_reg);
	wire raw2 = mtcm_src_tick(ck2, ptick, b_edge, b_s2_reg);
	wire run1 = m34 | (m2 & ck1 == mtcm_pkg::CK_PRESC);
	wire run2 = m2 | m3 | (m4 & ck2 == mtcm_pkg::CK_PRESC);
	wire tick1 = raw1 & run1;
	wire tick2 = raw2 & run2;
	wire uf1 = tick1 & (cnt1_reg == 16'h0000);
	wire uf2 = tick2 & (cnt2_reg == 16'h0000);

	// apb decode: writes commit at the edge where pready is seen high
	wire acc = psel_in & penable_in;
	wire wr = acc & pready_reg & pwrite_in;
	wire [15:0] wd16 = pwdata_in[15:0];
	wire wr_cnt1 = wr & (paddr_in == mtcm_pkg::OFS_CNT1);
	wire wr_cra = wr & (paddr_in == mtcm_pkg::OFS_CRA);
	wire wr_crb = wr & (paddr_in == mtcm_pkg::OFS_CRB);
	wire wr_cnt2 = wr & (paddr_in == mtcm_pkg::OFS_CNT2);
	wire wr_prsc = wr & (paddr_in == mtcm_pkg::OFS_PRSC);
	wire wr_ckc = wr & (paddr_in == mtcm_pkg::OFS_CKC);
	wire wr_mctrl = wr & (paddr_in == mtcm_pkg::OFS_MCTRL);
	wire wr_ictrl = wr & (paddr_in == mtcm_pkg::OFS_ICTRL);
	wire wr_iclr = wr & (paddr_in == mtcm_pkg::OFS_ICLR);
	wire hit = (paddr_in <= mtcm_pkg::OFS_ICLR) && (paddr_in[1:0] == 2'h0);

	// counter one: preset beats software write beats counting
	wire [15:0] cnt1_next = pre1 ? mtcm_pkg::CNT_PRESET :
		wr_cnt1 ? wd16 :
		(uf1 & m34) ? cra_reg :
		tick1 ? (cnt1_reg - 16'h0001) : cnt1_reg;

	// counter two: mode 3 reloads, modes 2 and 4 wrap to FFFF
	wire [15:0] cnt2_next = pre2 ? mtcm_pkg::CNT_PRESET :
		wr_cnt2 ? wd16 :
		(uf2 & m3) ? crb_reg :
		tick2 ? (cnt2_reg - 16'h0001) : cnt2_reg;

	// capture registers take the value from before any preset
	wire [15:0] cra_next = cap_a1 ? cnt1_reg :
		wr_cra ? wd16 : cra_reg;
	wire [15:0] crb_next = cap_b1 ? cnt1_reg :
		cap_b2 ? cnt2_reg :
		wr_crb ? wd16 : crb_reg;

	// prescaler down counter
	wire [PRSC_W-1:0] prsc_next = wr_prsc ? pwdata_in[PRSC_W-1:0] :
		prsc_reg;
	wire [PRSC_W-1:0] pcnt_next = wr_prsc ? pwdata_in[PRSC_W-1:0] :
		ptick ? prsc_reg : (pcnt_reg - {{(PRSC_W-1){1'b0}}, 1'b1});

	// pending flags; a set in the clearing cycle survives
	wire set_a = m2 ? cap_a1 : (m34 & uf1);
	wire set_b = cap_b1 | cap_b2;
	wire set_c = m2 & uf1;
	wire set_d = uf2;
	wire [3:0] pset = {set_d, set_c, set_b, set_a};
	wire [3:0] pclr = wr_iclr ? pwdata_in[3:0] : 4'h0;
	wire [3:0] pend_next = (pend_reg & ~pclr) | pset;
	localparam int IC_EN = mtcm_pkg::IC_EN_LSB;
	wire [3:0] ien_next = wr_ictrl ? pwdata_in[IC_EN +: 4] : ien_reg;

	// interrupt lines: A, B, C onto line A, D onto line B
	wire [3:0] pgate = pend_next & ien_next;
	wire irq_a_next = |pgate[mtcm_pkg::PND_C:mtcm_pkg::PND_A];
	wire irq_b_next = pgate[mtcm_pkg::PND_D];

	// A output: software level, toggles on reload when enabled
	wire [7:0] mctrl_next = wr_mctrl ? pwdata_in[7:0] : mctrl_reg;
	wire pin_a_next = wr_mctrl ? pwdata_in[mtcm_pkg::MC_AOUT] :
		(m34 & pen_a & uf1) ? ~pin_a_reg : pin_a_reg;
	wire [2:0] mode_nx = mctrl_next[mtcm_pkg::MC_MODE_LSB +: 3];
	wire oe_next = mctrl_next[mtcm_pkg::MC_PEN_A] &
		(mode_nx == mtcm_pkg::MODE_DUAL3 |
		mode_nx == mtcm_pkg::MODE_CAPT4);

	// read mux; the output level bit reads the live pin value
	wire [7:0] mctrl_rd = {pin_a_reg, mctrl_reg[6:0]};
	wire [31:0] rd_mux =
		(paddr_in == mtcm_pkg::OFS_CNT1) ? {16'h0000, cnt1_reg} :
		(paddr_in == mtcm_pkg::OFS_CRA) ? {16'h0000, cra_reg} :
		(paddr_in == mtcm_pkg::OFS_CRB) ? {16'h0000, crb_reg} :
		(paddr_in == mtcm_pkg::OFS_CNT2) ? {16'h0000, cnt2_reg} :
		(paddr_in == mtcm_pkg::OFS_PRSC) ?
			{{(32-PRSC_W){1'b0}}, prsc_reg} :
		(paddr_in == mtcm_pkg::OFS_CKC) ? {26'h0000000, ckc_reg} :
		(paddr_in == mtcm_pkg::OFS_MCTRL) ? {24'h000000, mctrl_rd} :
		(paddr_in == mtcm_pkg::OFS_ICTRL) ?
			{24'h000000, pend_reg, ien_reg} : 32'h00000000;

	// apb handshake: one wait state, then pready for one cycle
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else if (ce_in) begin
			pready_reg <= acc & ~pready_reg;
			pslverr_reg <= acc & ~pready_reg & ~hit;
			if (acc & ~pready_reg) begin
				prdata_reg <= rd_mux;
			end
		end
	end

	// timer state registers
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			cnt1_reg <= mtcm_pkg::CNT_RST;
			cnt2_reg <= mtcm_pkg::CNT_RST;
			cra_reg <= mtcm_pkg::CNT_RST;
			crb_reg <= mtcm_pkg::CNT_RST;
			prsc_reg <= '0;
			pcnt_reg <= '0;
		end else if (ce_in) begin
			cnt1_reg <= cnt1_next;
			cnt2_reg <= cnt2_next;
			cra_reg <= cra_next;
			crb_reg <= crb_next;
			prsc_reg <= prsc_next;
			pcnt_reg <= pcnt_next;
		end
	end

	// control, pending, pin and interrupt registers
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			ckc_reg <= mtcm_pkg::CKC_RST;
			mctrl_reg <= mtcm_pkg::MCTRL_RST;
			ien_reg <= mtcm_pkg::IRQ_RST;
			pend_reg <= mtcm_pkg::IRQ_RST;
			pin_a_reg <= 1'b0;
			oe_reg <= 1'b0;
			irq_a_reg <= 1'b0;
			irq_b_reg <= 1'b0;
		end else if (ce_in) begin
			ckc_reg <= wr_ckc ? pwdata_in[5:0] : ckc_reg;
			mctrl_reg <= mctrl_next;
			ien_reg <= ien_next;
			pend_reg <= pend_next;
			pin_a_reg <= pin_a_next;
			oe_reg <= oe_next;
			irq_a_reg <= irq_a_next;
			irq_b_reg <= irq_b_next;
		end
	end

	assign prdata_out = prdata_reg;
	assign pready_out = pready_reg;
	assign pslverr_out = pslverr_reg;
	assign timer_pin_a_out = pin_a_reg;
	assign timer_pin_a_oe_out = oe_reg;
	assign irq_a_out = irq_a_reg;
	assign irq_b_out = irq_b_reg;

	// checks on the capture, reload and flag behaviour
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	// capture then preset, as two observable results
	sequence s_cap_a_pre;
		ce_in && m2 && a_edge && pen_a;
	endsequence
	sequence s_a_done;
		cra_reg == $past(cnt1_reg) && cnt1_reg == mtcm_pkg::CNT_PRESET;
	endsequence
	sequence s_cap_b4_pre;
		ce_in && m4 && b_edge && pen_b;
	endsequence
	sequence s_b4_done;
		crb_reg == $past(cnt2_reg) && cnt2_reg == mtcm_pkg::CNT_PRESET;
	endsequence

	AST_CAP_A: assert property (ce_in && cap_a1 |=>
		cra_reg == $past(cnt1_reg) && pend_reg[mtcm_pkg::PND_A])
		else $error("mode 2 A capture wrong");
	AST_CAP_B2: assert property (ce_in && cap_b1 |=>
		crb_reg == $past(cnt1_reg) && pend_reg[mtcm_pkg::PND_B])
		else $error("mode 2 B capture wrong");
	AST_PRESET_A: assert property (s_cap_a_pre |=> s_a_done)
		else $error("mode 2 A preset wrong");
	AST_CAP_B4: assert property (s_cap_b4_pre |=> s_b4_done)
		else $error("mode 4 B capture preset wrong");
	AST_STOP1: assert property (ce_in && m2 && !pre1 && !wr_cnt1 &&
		(ck1 == mtcm_pkg::CK_EVENT || ck1 == mtcm_pkg::CK_PACC)
		|=> $stable(cnt1_reg))
		else $error("counter one ran on event clock in mode 2");
	AST_STOP2: assert property (ce_in && m4 && !pre2 && !wr_cnt2 &&
		(ck2 == mtcm_pkg::CK_EVENT || ck2 == mtcm_pkg::CK_PACC)
		|=> $stable(cnt2_reg))
		else $error("counter two ran on event clock in mode 4");
	AST_RELOAD1: assert property (ce_in && m34 && uf1 && !wr &&
		pen_a |=> cnt1_reg == $past(cra_reg) &&
		timer_pin_a_out != $past(timer_pin_a_out) &&
		pend_reg[mtcm_pkg::PND_A])
		else $error("counter one reload or toggle wrong");
	AST_RELOAD2: assert property (ce_in && m3 && uf2 && !wr |=>
		cnt2_reg == $past(crb_reg) && pend_reg[mtcm_pkg::PND_D])
		else $error("counter two reload wrong");
	AST_UF_C: assert property (ce_in && m2 && uf1 && !pre1 &&
		!wr_cnt1 |=> cnt1_reg == mtcm_pkg::CNT_PRESET &&
		pend_reg[mtcm_pkg::PND_C])
		else $error("mode 2 underflow flag wrong");
	AST_SET_WINS: assert property (ce_in && set_d && wr_iclr |=>
		pend_reg[mtcm_pkg::PND_D])
		else $error("pending set lost to clear");
	AST_IRQ_MAP: assert property (ce_in && pend_reg[mtcm_pkg::PND_C] &&
		ien_reg[mtcm_pkg::PND_C] && !wr |=> irq_a_out ##0
		(irq_b_out == (pend_reg[3] && ien_reg[3])))
		else $error("interrupt line mapping wrong");
	AST_LEVEL: assert property (ce_in && wr_mctrl |=>
		timer_pin_a_out == $past(pwdata_in[mtcm_pkg::MC_AOUT]))
		else $error("A output start level not taken");

	// counter two wraps in modes 2 and 4 and keeps its own flag
	sequence s_uf2_wrap;
		ce_in && uf2 && !m3 && !pre2 && !wr_cnt2;
	endsequence
	sequence s_wrapped2;
		cnt2_reg == mtcm_pkg::CNT_PRESET && pend_reg[mtcm_pkg::PND_D];
	endsequence
	AST_UF_D: assert property (s_uf2_wrap |=> s_wrapped2)
		else $error("counter two wrap or flag wrong");

	// mode 4 capture copies counter two into B and sets pending B
	AST_CAP_B4N: assert property (ce_in && cap_b2 |=>
		crb_reg == $past(cnt2_reg) && pend_reg[mtcm_pkg::PND_B])
		else $error("mode 4 B capture wrong");
	AST_IDLE1: assert property (ce_in && !m2 && !m34 && !wr_cnt1 |=>
		$stable(cnt1_reg))
		else $error("counter one ran outside modes 2 to 4");
	AST_IRQ_B: assert property (ce_in && pend_reg[mtcm_pkg::PND_D] &&
		ien_reg[mtcm_pkg::PND_D] && !wr |=> irq_b_out)
		else $error("interrupt line B missing");
	AST_HOLD_A: assert property (ce_in && m2 && !wr_mctrl |=>
		$stable(timer_pin_a_out))
		else $error("A output moved in mode 2");

	// mode field of the word being written to mode control
	wire [2:0] wmode = pwdata_in[mtcm_pkg::MC_MODE_LSB +: 3];
	AST_OE_A: assert property (ce_in && wr_mctrl |=>
		timer_pin_a_oe_out == ($past(pwdata_in[mtcm_pkg::MC_PEN_A]) &&
		($past(wmode) == mtcm_pkg::MODE_DUAL3 ||
		$past(wmode) == mtcm_pkg::MODE_CAPT4)))
		else $error("A output enable wrong");

	// the prescaler reloads its divide value after every tick
	AST_PRESC: assert property (ce_in && ptick && !wr_prsc |=>
		pcnt_reg == $past(prsc_reg))
		else $error("prescaler reload wrong");

	// a B event clocks counter two down by one in mode 3
	AST_EVT2: assert property (ce_in && m3 && b_edge &&
		ck2 == mtcm_pkg::CK_EVENT && !wr_cnt2 && cnt2_reg != 16'h0000
		|=> cnt2_reg == $past(cnt2_reg) - 16'h0001)
		else $error("counter two missed a B event in mode 3");

endmodule // mtcm_top

// *** logic/mtcm_pkg.sv ***
// constants shared by the multifunction timer capture/timer block
package mtcm_pkg;
	// register byte offsets on the APB
	localparam logic [7:0] OFS_CNT1 = 8'h00;
	localparam logic [7:0] OFS_CRA = 8'h04;
	localparam logic [7:0] OFS_CRB = 8'h08;
	localparam logic [7:0] OFS_CNT2 = 8'h0C;
	localparam logic [7:0] OFS_PRSC = 8'h10;
	localparam logic [7:0] OFS_CKC = 8'h14;
	localparam logic [7:0] OFS_MCTRL = 8'h18;
	localparam logic [7:0] OFS_ICTRL = 8'h1C;
	localparam logic [7:0] OFS_ICLR = 8'h20;
	// counter width and preset value
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_PRESET = 16'hFFFF;
	localparam logic [15:0] CNT_RST = 16'h0000;
	// timer mode control fields
	localparam int MC_MODE_LSB = 0;
	localparam int MC_EDGE_A = 3;
	localparam int MC_EDGE_B = 4;
	localparam int MC_PEN_A = 5;
	localparam int MC_PEN_B = 6;
	localparam int MC_AOUT = 7;
	localparam logic [7:0] MCTRL_RST = 8'h00;
	// mode select codes
	localparam logic [2:0] MODE_CAP2 = 3'h2;
	localparam logic [2:0] MODE_DUAL3 = 3'h3;
	localparam logic [2:0] MODE_CAPT4 = 3'h4;
	// clock select control fields and codes
	localparam int CK1_LSB = 0;
	localparam int CK2_LSB = 3;
	localparam logic [5:0] CKC_RST = 6'h00;
	localparam logic [2:0] CK_NONE = 3'h0;
	localparam logic [2:0] CK_PRESC = 3'h1;
	localparam logic [2:0] CK_EVENT = 3'h2;
	localparam logic [2:0] CK_PACC = 3'h3;
	// interrupt control fields and pending bit positions
	localparam int IC_EN_LSB = 0;
	localparam int IC_PND_LSB = 4;
	localparam int PND_A = 0;
	localparam int PND_B = 1;
	localparam int PND_C = 2;
	localparam int PND_D = 3;
	localparam logic [3:0] IRQ_RST = 4'h0;
	// prescaler
	localparam int PRSC_W_DEF = 8;
endpackage

// *** dv/mtcm_pin_model.sv ***
// model of the external sources that drive timer pins a and b
`timescale 1ns/100ps
module mtcm_pin_model (
	input wire logic sys_clk_in,
	output logic pin_a_out,
	output logic pin_b_out
);
	// both pins idle low
	initial begin
		pin_a_out = 1'b0;
		pin_b_out = 1'b0;
	end
	// change one pin after an edge, then hold it three cycles
	task automatic drive(input logic sel_b, input logic lvl);
		@(posedge sys_clk_in);
		if (sel_b) begin
			pin_b_out <= lvl;
		end else begin
			pin_a_out <= lvl;
		end
		repeat (3) @(posedge sys_clk_in);
	endtask
endmodule // mtcm_pin_model

// *** dv/test_multi_timer_capture_modes.sv ***
// self-checking bench for the capture and timer modes
`timescale 1ns/100ps
module test_multi_timer_capture_modes;
	logic sys_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic ce_in = 1'b1;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h00000000;
	logic [31:0] prdata_out, rd;
	logic pready_out, pslverr_out, err, pin_a, pin_b;
	logic timer_pin_a_out, timer_pin_a_oe_out, irq_a_out, irq_b_out;
	int errors = 0;
	int comparisons = 0;
	int n1;
	// clock at 40 mhz
	always #12.5 sys_clk_in = ~sys_clk_in;
	mtcm_top mtcm_top_inst (.sys_clk_in, .reset_in, .ce_in,
		.psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
		.prdata_out, .pready_out, .pslverr_out,
		.timer_pin_a_in(pin_a), .timer_pin_b_in(pin_b),
		.timer_pin_a_out, .timer_pin_a_oe_out, .irq_a_out, .irq_b_out);
	mtcm_pin_model mtcm_pin_model_inst (.sys_clk_in,
		.pin_a_out(pin_a), .pin_b_out(pin_b));
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer, waiting for pready under a bound
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 100);
		if (n >= 100) errors++;
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h00000000);
		check(rd, exp);
	endtask
	// one full pulse on pin b, then let the synchroniser settle
	task automatic pulse_b;
		mtcm_pin_model_inst.drive(1'b1, 1'b1);
		mtcm_pin_model_inst.drive(1'b1, 1'b0);
		repeat (6) @(posedge sys_clk_in);
	endtask
	// cycles until the a output changes
	task automatic wait_toggle(output int n);
		logic l;
		l = timer_pin_a_out;
		n = 0;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (timer_pin_a_out === l && n < 50);
	endtask
	// reset values and an unmapped address
	task automatic test_reset;
		rdchk(mtcm_pkg::OFS_CNT1, 32'h00000000);
		rdchk(mtcm_pkg::OFS_MCTRL, 32'h00000000);
		rdchk(mtcm_pkg::OFS_ICTRL, 32'h00000000);
		rdchk(8'h24, 32'h00000000);
		check({31'h0, err}, 32'h00000001);
		$display("test reset done");
	endtask
	// mode 2 captures on a (rising, preset) and b (falling, no preset)
	task automatic test_mode2_capture;
		wr(mtcm_pkg::OFS_ICTRL, 32'h00000001);
		wr(mtcm_pkg::OFS_CNT1, 32'h00001234);
		wr(mtcm_pkg::OFS_MCTRL, 32'h0000002A);
		mtcm_pin_model_inst.drive(1'b0, 1'b1);
		repeat (6) @(posedge sys_clk_in);
		rdchk(mtcm_pkg::OFS_CRA, 32'h00001234);
		rdchk(mtcm_pkg::OFS_CNT1, 32'h0000FFFF);
		rdchk(mtcm_pkg::OFS_ICTRL, 32'h00000011);
		check({31'h0, irq_a_out}, 32'h00000001);
		wr(mtcm_pkg::OFS_CNT1, 32'h00000ABC);
		mtcm_pin_model_inst.drive(1'b1, 1'b1);
		repeat (6) @(posedge sys_clk_in);
		rdchk(mtcm_pkg::OFS_ICTRL, 32'h00000011);
		mtcm_pin_model_inst.drive(1'b1, 1'b0);
		repeat (6) @(posedge sys_clk_in);
		rdchk(mtcm_pkg::OFS_CRB, 32'h00000ABC);
		rdchk(mtcm_pkg::OFS_CNT1, 32'h00000ABC);
		rdchk(mtcm_pkg::OFS_ICTRL, 32'h00000031);
		wr(mtcm_pkg::OFS_ICLR, 32'h00000003);
		rdchk(mtcm_pkg::OFS_ICTRL, 32'h00000001);
		check({31'h0, irq_a_out}, 32'h00000000);
		$display("test mode2 capture done");
	endtask
	// mode 2 event source stops counter one, counter two runs
	task automatic test_mode2_sources;
		wr(mtcm_pkg::OFS_CNT1, 32'h00000100);
		wr(mtcm_pkg::OFS_CNT2, 32'h00000003);
		wr(mtcm_pkg::OFS_ICTRL, 32'h00000008);
		wr(mtcm_pkg::OFS_CKC, 32'h0000000A);
		pulse_b();
		rdchk(mtcm_pkg::OFS_CNT1, 32'h00000100);
		rdchk(mtcm_pkg::OFS_ICTRL, 32'h000000A8);
		check({31'h0, irq_b_out}, 32'h00000001);
		$display("test mode2 sources done");
	endtask
	// mode 3 square wave, reload period and counter two events
	task automatic test_mode3;
		wr(mtcm_pkg::OFS_CKC, 32'h00000000);
		wr(mtcm_pkg::OFS_ICLR, 32'h0000000F);
		wr(mtcm_pkg::OFS_ICTRL, 32'h00000001);
		wr(mtcm_pkg::OFS_CRA, 32'h00000003);
		wr(mtcm_pkg::OFS_CNT1, 32'h00000000);
		wr(mtcm_pkg::OFS_MCTRL, 32'h000000A3);
		// let the registered pin outputs settle before looking
		@(posedge sys_clk_in);
		check({31'h0, timer_pin_a_out}, 32'h00000001);
		check({31'h0, timer_pin_a_oe_out}, 32'h00000001);
		wr(mtcm_pkg::OFS_CKC, 32'h00000001);
		wait_toggle(n1);
		check({31'h0, timer_pin_a_out}, 32'h00000000);
		wait_toggle(n1);
		check(32'(n1), 32'h00000004);
		check({31'h0, irq_a_out}, 32'h00000001);
		wr(mtcm_pkg::OFS_CKC, 32'h00000000);
		wr(mtcm_pkg::OFS_MCTRL, 32'h000000B3);
		wr(mtcm_pkg::OFS_CRB, 32'h00000002);
		wr(mtcm_pkg::OFS_CNT2, 32'h00000000);
		wr(mtcm_pkg::OFS_ICLR, 32'h0000000F);
		wr(mtcm_pkg::OFS_CKC, 32'h00000010);
		pulse_b();
		pulse_b();
		rdchk(mtcm_pkg::OFS_CNT2, 32'h00000001);
		rdchk(mtcm_pkg::OFS_ICTRL, 32'h00000081);
		$display("test mode3 done");
	endtask
	// mode 4 capture of counter two with and without preset
	task automatic test_mode4;
		wr(mtcm_pkg::OFS_CKC, 32'h00000000);
		wr(mtcm_pkg::OFS_ICLR, 32'h0000000F);
		wr(mtcm_pkg::OFS_ICTRL, 32'h00000002);
		wr(mtcm_pkg::OFS_CNT2, 32'h00000055);
		wr(mtcm_pkg::OFS_MCTRL, 32'h00000054);
		pulse_b();
		rdchk(mtcm_pkg::OFS_CRB, 32'h00000055);
		rdchk(mtcm_pkg::OFS_CNT2, 32'h0000FFFF);
		rdchk(mtcm_pkg::OFS_ICTRL, 32'h00000022);
		check({31'h0, irq_a_out}, 32'h00000001);
		wr(mtcm_pkg::OFS_MCTRL, 32'h00000014);
		wr(mtcm_pkg::OFS_CNT2, 32'h00000007);
		wr(mtcm_pkg::OFS_CNT1, 32'h00000009);
		wr(mtcm_pkg::OFS_CKC, 32'h00000012);
		pulse_b();
		rdchk(mtcm_pkg::OFS_CRB, 32'h00000007);
		rdchk(mtcm_pkg::OFS_CNT2, 32'h00000007);
		rdchk(mtcm_pkg::OFS_CNT1, 32'h00000008);
		$display("test mode4 done");
	endtask
	// clock enable low freezes synchronisers, so a b pulse is lost
	task automatic test_clock_enable;
		@(posedge sys_clk_in);
		ce_in <= 1'b0;
		pulse_b();
		@(posedge sys_clk_in);
		ce_in <= 1'b1;
		rdchk(mtcm_pkg::OFS_CNT1, 32'h00000008);
		rdchk(mtcm_pkg::OFS_CRB, 32'h00000007);
		$display("test clock enable done");
	endtask
	// verdict and end of run
	task automatic tally_and_finish;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		test_reset();
		test_mode2_capture();
		test_mode2_sources();
		test_mode3();
		test_mode4();
		test_clock_enable();
		tally_and_finish();
	end
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		errors++;
		tally_and_finish();
	end
endmodule // test_multi_timer_capture_modes
